// File: sgd_map.vh
// constants of the scatter-gather descriptor fetch block
`ifndef SGD_MAP_VH
`define SGD_MAP_VH

// descriptor word indexes; byte offset is four times the index
`define SGD_W_NXT_LO     4'h0
`define SGD_W_NXT_HI     4'h1
`define SGD_W_BUF_LO     4'h2
`define SGD_W_BUF_HI     4'h3
`define SGD_W_CTL        4'h6
`define SGD_W_STS        4'h7
`define SGD_W_USER_WORD_0       4'h8
`define SGD_W_USER_WORD_4       4'hC
`define SGD_W_END        4'hF
`define SGD_APP_LAST     3'h4

// descriptor field positions
`define SGD_LEN_HI       22
`define SGD_LAST_BIT     26
`define SGD_FIRST_BIT    27
`define SGD_CPL_BIT      31
`define SGD_PTR_LO_BIT   6

// register byte addresses and field selects
`define SGD_A_CTRL       8'h00
`define SGD_A_STAT       8'h04
`define SGD_A_ISTAT      8'h08
`define SGD_A_IMASK      8'h0C
`define SGD_A_CH0_NIB    4'h1
`define SGD_F_CUR_LO     2'h0
`define SGD_F_CUR_HI     2'h1
`define SGD_F_TAIL_LO    2'h2
`define SGD_F_TAIL_HI    2'h3

// control register bits
`define SGD_C_RUN0       0
`define SGD_C_RUN1       1
`define SGD_C_USER       2
`define SGD_C_WIDE       3
`define SGD_C_IOC        4
`define SGD_CTRL_W       5

// reset values
`define SGD_ZERO32       32'h0000_0000
`define SGD_ZERO64       64'h0000_0000_0000_0000

`endif

// File: sgd_appmem.v
// small memory holding the user application words of the active descriptor
`timescale 1ns/1ps
`default_nettype none
module sgd_appmem
(
  // clock
  input  wire        i_ref_clk,
  // write port
  input  wire        i_we,
  input  wire [2:0]  i_waddr,
  input  wire [31:0] i_wdata,
  // read port, data one cycle after the address
  input  wire [2:0]  i_raddr,
  output reg  [31:0] o_rdata
);

  reg [31:0] mem [0:7];

  // no reset: contents are always written before they are read back
  always @(posedge i_ref_clk)
  begin
    if (i_we)
    begin
      mem[i_waddr] <= i_wdata;
    end
    o_rdata <= mem[i_raddr];
  end

endmodule
`default_nettype wire

// File: sgd_fetch.v
// scatter-gather descriptor fetch and write-back engine for two chains
`timescale 1ns/1ps
`default_nettype none
`include "sgd_map.vh"
module sgd_fetch
(
  // clock and reset
  input  wire        i_ref_clk,
  input  wire        i_rst,
  // register port
  input  wire [7:0]  i_addr,
  input  wire [31:0] i_wdata,
  input  wire        i_wr,
  input  wire        i_rd,
  output reg  [31:0] o_rdata,
  // interrupt
  output reg         o_irq,
  // memory word master
  output reg         o_mem_req,
  output reg         o_mem_we,
  output reg  [63:0] o_mem_addr,
  output reg  [31:0] o_mem_wdata,
  input  wire        i_mem_ack,
  input  wire [31:0] i_mem_rdata,
  // buffer command to the data movers
  output reg         o_buf_valid,
  output reg         o_buf_chan,
  output reg  [63:0] o_buf_addr,
  output reg  [22:0] o_buf_len,
  output reg         o_buf_first,
  output reg         o_buf_last,
  input  wire        i_buf_done,
  input  wire [22:0] i_buf_count,
  // status stream words for stream_to_mem write-back
  input  wire        i_app_wr,
  input  wire [2:0]  i_app_idx,
  input  wire [31:0] i_app_data
);

  localparam ST_IDLE  = 3'd0;
  localparam ST_FETCH = 3'd1;
  localparam ST_DISP  = 3'd2;
  localparam ST_WBSTS = 3'd3;
  localparam ST_WBRD  = 3'd4;
  localparam ST_WBAPP = 3'd5;
  localparam ST_NEXT  = 3'd6;

  reg  [2:0]               state;
  reg  [`SGD_CTRL_W-1:0]   ctrl;
  reg  [1:0]               irq_stat;
  reg  [1:0]               irq_mask;
  reg                      ch;
  reg                      last_ch;
  reg  [3:0]               fidx;
  reg  [2:0]               app_idx;
  reg  [31:0]              nxt_lo;
  reg  [31:0]              nxt_hi;
  reg  [31:0]              cur_lo  [0:1];
  reg  [31:0]              cur_hi  [0:1];
  reg  [31:0]              tail_lo [0:1];
  reg  [31:0]              tail_hi [0:1];
  reg                      active  [0:1];
  wire                     wide;
  wire                     user;
  wire [63:0]              cur64;
  wire                     is_tail;
  wire                     pick;
  wire                     any_act;
  wire [3:0]               nidx;
  wire [31:0]              app_rdata;
  wire                     app_we;
  wire [2:0]               app_waddr;
  wire [31:0]              app_wdata;
  wire                     sw_wr;

  assign wide  = ctrl[`SGD_C_WIDE];
  assign user  = ctrl[`SGD_C_USER];
  assign sw_wr = i_wr;

  //////////////////////////////////////////////////////////////////////////////
  // helper functions

  // next word to fetch; skips reserved words and unused optional words
  function [3:0] next_fetch;
    input [3:0] idx;
    input       w;
    input       u;
    begin
      case (idx)
        `SGD_W_NXT_LO: next_fetch = w ? `SGD_W_NXT_HI : `SGD_W_BUF_LO;
        `SGD_W_NXT_HI: next_fetch = `SGD_W_BUF_LO;
        `SGD_W_BUF_LO: next_fetch = w ? `SGD_W_BUF_HI : `SGD_W_CTL;
        `SGD_W_BUF_HI: next_fetch = `SGD_W_CTL;
        `SGD_W_CTL:    next_fetch = u ? `SGD_W_USER_WORD_0 : `SGD_W_END;
        `SGD_W_USER_WORD_4:   next_fetch = `SGD_W_END;
        default:       next_fetch = idx + 4'h1;
      endcase
    end
  endfunction

  // byte address of a descriptor word
  function [63:0] word_addr;
    input [63:0] base;
    input [3:0]  idx;
    begin
      word_addr = base + {58'h0, idx, 2'b00};
    end
  endfunction

  // register window of one channel
  function chan_hit;
    input [7:0] a;
    input       c;
    begin
      chan_hit = (a[7:4] == (`SGD_A_CH0_NIB + {3'h0, c}));
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // shared decode

  // low six pointer bits are not address bits; the chain assumes aligned descriptors
  assign cur64   = {(wide ? cur_hi[ch] : `SGD_ZERO32),
                    cur_lo[ch][31:`SGD_PTR_LO_BIT], 6'h00};
  assign is_tail = (cur_lo[ch][31:`SGD_PTR_LO_BIT] == tail_lo[ch][31:`SGD_PTR_LO_BIT]) &&
                   (!wide || (cur_hi[ch] == tail_hi[ch]));
  // alternate between chains when both have work
  assign any_act = active[0] | active[1];
  assign pick    = active[1] & (~active[0] | ~last_ch);
  assign nidx    = next_fetch(fidx, wide, user);

  // user words come from memory on fetch, from the status stream while chain 1 waits in dispatch
  assign app_we    = (state == ST_FETCH && i_mem_ack && fidx[3]) ||
                     (state == ST_DISP && ch && i_app_wr);
  assign app_waddr = (state == ST_FETCH) ? fidx[2:0] : i_app_idx;
  assign app_wdata = (state == ST_FETCH) ? i_mem_rdata : i_app_data;

  sgd_appmem u_appmem
  (
    .i_ref_clk (i_ref_clk),
    .i_we      (app_we),
    .i_waddr   (app_waddr),
    .i_wdata   (app_wdata),
    .i_raddr   (app_idx),
    .o_rdata   (app_rdata)
  );

  //////////////////////////////////////////////////////////////////////////////
  // per-chain pointer registers

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1)
    begin : g_chain
      wire hit;
      wire adv;
      wire stop;
      assign hit  = sw_wr && chan_hit(i_addr, (g == 1));
      assign adv  = (state == ST_NEXT) && (ch == g) && !is_tail;
      assign stop = (state == ST_NEXT) && (ch == g) && is_tail;
      always @(posedge i_ref_clk or posedge i_rst)
      begin
        if (i_rst)
        begin
          cur_lo[g]  <= `SGD_ZERO32;
          cur_hi[g]  <= `SGD_ZERO32;
          tail_lo[g] <= `SGD_ZERO32;
          tail_hi[g] <= `SGD_ZERO32;
          active[g]  <= 1'b0;
        end
        else
        begin
          // current pointer is only writable while the chain is stopped
          if (hit && !active[g] && i_addr[3:2] == `SGD_F_CUR_LO)
          begin
            cur_lo[g] <= i_wdata;
          end
          if (hit && !active[g] && i_addr[3:2] == `SGD_F_CUR_HI)
          begin
            cur_hi[g] <= i_wdata;
          end
          if (adv)
          begin
            cur_lo[g] <= nxt_lo;
            cur_hi[g] <= nxt_hi;
          end
          if (hit && i_addr[3:2] == `SGD_F_TAIL_LO)
          begin
            tail_lo[g] <= i_wdata;
          end
          if (hit && i_addr[3:2] == `SGD_F_TAIL_HI)
          begin
            tail_hi[g] <= i_wdata;
          end
          // a tail write starts a running chain; while halted it only moves the pause point
          if (!ctrl[g] || stop)
          begin
            active[g] <= 1'b0;
          end
          else if (hit && i_addr[3])
          begin
            active[g] <= 1'b1;
          end
        end
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // register port and interrupt

  always @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      ctrl     <= {`SGD_CTRL_W{1'b0}};
      irq_mask <= 2'b00;
      irq_stat <= 2'b00;
      o_irq    <= 1'b0;
      o_rdata  <= `SGD_ZERO32;
    end
    else
    begin
      if (sw_wr && i_addr == `SGD_A_CTRL)
      begin
        ctrl <= i_wdata[`SGD_CTRL_W-1:0];
      end
      if (sw_wr && i_addr == `SGD_A_IMASK)
      begin
        irq_mask <= i_wdata[1:0];
      end
      // set wins over a write-one clear in the same cycle
      irq_stat <= (irq_stat & ~((sw_wr && i_addr == `SGD_A_ISTAT) ? i_wdata[1:0] : 2'b00)) |
                  ((state == ST_NEXT && ctrl[`SGD_C_IOC]) ? (ch ? 2'b10 : 2'b01) : 2'b00);
      o_irq    <= |(irq_stat & irq_mask);
      // unmapped addresses read as zero
      o_rdata  <= `SGD_ZERO32;
      if (i_rd)
      begin
        if (i_addr == `SGD_A_CTRL)
        begin
          o_rdata <= {27'h0, ctrl};
        end
        else if (i_addr == `SGD_A_STAT)
        begin
          o_rdata <= {25'h0, state, ch, active[1], active[0], any_act};
        end
        else if (i_addr == `SGD_A_ISTAT)
        begin
          o_rdata <= {30'h0, irq_stat};
        end
        else if (i_addr == `SGD_A_IMASK)
        begin
          o_rdata <= {30'h0, irq_mask};
        end
        else if (chan_hit(i_addr, 1'b0) || chan_hit(i_addr, 1'b1))
        begin
          case (i_addr[3:2])
            `SGD_F_CUR_LO:  o_rdata <= cur_lo[i_addr[5]];
            `SGD_F_CUR_HI:  o_rdata <= cur_hi[i_addr[5]];
            `SGD_F_TAIL_LO: o_rdata <= tail_lo[i_addr[5]];
            default:        o_rdata <= tail_hi[i_addr[5]];
          endcase
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // descriptor sequencer

  always @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      state       <= ST_IDLE;
      ch          <= 1'b0;
      last_ch     <= 1'b1;
      fidx        <= `SGD_W_NXT_LO;
      app_idx     <= 3'h0;
      nxt_lo      <= `SGD_ZERO32;
      nxt_hi      <= `SGD_ZERO32;
      o_mem_req   <= 1'b0;
      o_mem_we    <= 1'b0;
      o_mem_addr  <= `SGD_ZERO64;
      o_mem_wdata <= `SGD_ZERO32;
      o_buf_valid <= 1'b0;
      o_buf_chan  <= 1'b0;
      o_buf_addr  <= `SGD_ZERO64;
      o_buf_len   <= 23'h00_0000;
      o_buf_first <= 1'b0;
      o_buf_last  <= 1'b0;
    end
    else
    begin
      case (state)
        ST_IDLE:
        begin
          if (any_act)
          begin
            ch         <= pick;
            last_ch    <= pick;
            fidx       <= `SGD_W_NXT_LO;
            o_mem_req  <= 1'b1;
            o_mem_we   <= 1'b0;
            o_mem_addr <= {(wide ? cur_hi[pick] : `SGD_ZERO32),
                           cur_lo[pick][31:`SGD_PTR_LO_BIT], 6'h00};
            state      <= ST_FETCH;
          end
        end
        ST_FETCH:
        begin
          if (i_mem_ack)
          begin
            case (fidx)
              `SGD_W_NXT_LO: nxt_lo <= {i_mem_rdata[31:`SGD_PTR_LO_BIT], 6'h00};
              `SGD_W_NXT_HI: nxt_hi <= i_mem_rdata;
              `SGD_W_BUF_LO: o_buf_addr[31:0]  <= i_mem_rdata;
              `SGD_W_BUF_HI: o_buf_addr[63:32] <= i_mem_rdata;
              `SGD_W_CTL:
              begin
                o_buf_len   <= i_mem_rdata[`SGD_LEN_HI:0];
                o_buf_last  <= i_mem_rdata[`SGD_LAST_BIT];
                o_buf_first <= i_mem_rdata[`SGD_FIRST_BIT];
              end
              default:       nxt_hi <= nxt_hi;
            endcase
            // narrow mode keeps the upper halves at zero
            if (fidx == `SGD_W_NXT_LO && !wide)
            begin
              nxt_hi <= `SGD_ZERO32;
            end
            if (fidx == `SGD_W_NXT_LO && !wide)
            begin
              o_buf_addr[63:32] <= `SGD_ZERO32;
            end
            fidx       <= nidx;
            o_mem_addr <= word_addr(cur64, nidx);
            if (nidx == `SGD_W_END)
            begin
              o_mem_req   <= 1'b0;
              o_buf_valid <= 1'b1;
              o_buf_chan  <= ch;
              state       <= ST_DISP;
            end
          end
        end
        ST_DISP:
        begin
          // command stands until the mover reports the buffer finished
          if (i_buf_done)
          begin
            o_buf_valid <= 1'b0;
            o_mem_req   <= 1'b1;
            o_mem_we    <= 1'b1;
            o_mem_addr  <= word_addr(cur64, `SGD_W_STS);
            o_mem_wdata <= {1'b1, 8'h00, i_buf_count};
            state       <= ST_WBSTS;
          end
        end
        ST_WBSTS:
        begin
          if (i_mem_ack)
          begin
            o_mem_req <= 1'b0;
            o_mem_we  <= 1'b0;
            app_idx   <= 3'h0;
            state     <= user ? ST_WBRD : ST_NEXT;
          end
        end
        ST_WBRD:
        begin
          // one cycle for the memory read register to catch up
          state <= ST_WBAPP;
        end
        ST_WBAPP:
        begin
          if (!o_mem_req)
          begin
            o_mem_req   <= 1'b1;
            o_mem_we    <= 1'b1;
            o_mem_addr  <= word_addr(cur64, {1'b1, app_idx});
            o_mem_wdata <= app_rdata;
          end
          else if (i_mem_ack)
          begin
            o_mem_req <= 1'b0;
            o_mem_we  <= 1'b0;
            if (app_idx == `SGD_APP_LAST)
            begin
              state <= ST_NEXT;
            end
            else
            begin
              app_idx <= app_idx + 3'h1;
              state   <= ST_WBRD;
            end
          end
        end
        ST_NEXT:
        begin
          // pointer advance or stop is done in the chain registers
          state <= ST_IDLE;
        end
        default:
        begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// File: sgd_fetch_properties.sv
// assertion checker for the descriptor fetch engine ports
`timescale 1ns/1ps
`default_nettype none
module sgd_props
(
  // clock, reset and register writes
  input wire logic        i_ref_clk,
  input wire logic        i_rst,
  input wire logic [7:0]  i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic        i_wr,
  // memory master
  input wire logic        o_mem_req,
  input wire logic        o_mem_we,
  input wire logic [63:0] o_mem_addr,
  input wire logic [31:0] o_mem_wdata,
  input wire logic        i_mem_ack,
  // buffer command
  input wire logic        o_buf_valid,
  input wire logic        o_buf_chan,
  input wire logic [63:0] o_buf_addr,
  input wire logic [22:0] o_buf_len,
  input wire logic        o_buf_first,
  input wire logic        o_buf_last,
  input wire logic        i_buf_done,
  input wire logic [22:0] i_buf_count
);
  logic        wide_q;
  logic        user_q;
  logic [22:0] cnt_q;
  ////////////////////////////////////////////////////////////////////////////////
  // shadow of the mode bits and the last reported count; the bench only changes
  // mode while both chains are idle, so no settling window is needed
  always @(posedge i_ref_clk or posedge i_rst)
    if (i_rst)
    begin
      wide_q <= 1'b0;
      user_q <= 1'b0;
      cnt_q  <= 23'h00_0000;
    end
    else
    begin
      if (i_wr && i_addr == 8'h00)
      begin
        wide_q <= i_wdata[3];
        user_q <= i_wdata[2];
      end
      if (i_buf_done && o_buf_valid)
        cnt_q <= i_buf_count;
    end
  ////////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  property p_req_hold;
    o_mem_req && !i_mem_ack |=> o_mem_req && $stable(o_mem_addr) && $stable(o_mem_we);
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("memory request changed early");
  property p_read_words;
    o_mem_req && !o_mem_we |-> !(o_mem_addr[5:2] inside {4'h4, 4'h5, 4'h7, [4'hD:4'hF]});
  endproperty
  a_read_words: assert property (p_read_words) else $error("read of a skipped word");
  property p_write_words;
    o_mem_req && o_mem_we |-> o_mem_addr[5:2] inside {4'h7, [4'h8:4'hC]} && o_mem_addr[1:0] == 2'h0;
  endproperty
  a_write_words: assert property (p_write_words) else $error("write outside status words");
  property p_user_gate;
    o_mem_req && !user_q |-> o_mem_addr[5:2] < 4'h8;
  endproperty
  a_user_gate: assert property (p_user_gate) else $error("user word touched while off");
  property p_narrow;
    o_mem_req && !wide_q |-> o_mem_addr[63:32] == 32'h0 && !(o_mem_addr[5:2] inside {4'h1, 4'h3});
  endproperty
  a_narrow: assert property (p_narrow) else $error("upper word used in narrow mode");
  property p_status_word;
    o_mem_req && o_mem_we && o_mem_addr[5:2] == 4'h7 |-> o_mem_wdata == {1'b1, 8'h00, cnt_q};
  endproperty
  a_status_word: assert property (p_status_word) else $error("status word wrong");
  property p_buf_hold;
    o_buf_valid && !i_buf_done |=> o_buf_valid && $stable({o_buf_chan, o_buf_addr, o_buf_len,
                                                          o_buf_first, o_buf_last});
  endproperty
  a_buf_hold: assert property (p_buf_hold) else $error("buffer command moved");
  property p_buf_drop;
    o_buf_valid && i_buf_done |=> !o_buf_valid ##1 !o_buf_valid;
  endproperty
  a_buf_drop: assert property (p_buf_drop) else $error("buffer command not retired");
endmodule
bind sgd_fetch sgd_props u_props
(
  .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
  .o_mem_req(o_mem_req), .o_mem_we(o_mem_we), .o_mem_addr(o_mem_addr),
  .o_mem_wdata(o_mem_wdata), .i_mem_ack(i_mem_ack), .o_buf_valid(o_buf_valid),
  .o_buf_chan(o_buf_chan), .o_buf_addr(o_buf_addr), .o_buf_len(o_buf_len),
  .o_buf_first(o_buf_first), .o_buf_last(o_buf_last), .i_buf_done(i_buf_done),
  .i_buf_count(i_buf_count)
);
`default_nettype wire

// File: sgd_mem_model.sv
// word-wide system memory holding descriptor chains, with a set ack delay
`timescale 1ns/1ps
`default_nettype none
module sgd_mem_model
(
  // clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst,
  // request from the engine
  input  wire logic        i_req,
  input  wire logic        i_we,
  input  wire logic [63:0] i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wait,
  // answer
  output logic             o_ack,
  output logic [31:0]      o_rdata
);
  logic [31:0] words [0:255];
  logic [3:0]  cnt;
  ////////////////////////////////////////////////////////////////////////////////
  // one 32-bit word per request in a 1 KiB window; i_wait stalls the ack
  always @(posedge i_ref_clk or posedge i_rst)
    if (i_rst)
    begin
      o_ack   <= 1'b0;
      cnt     <= 4'h0;
      o_rdata <= 32'h0000_0000;
    end
    else if (i_req && !o_ack && cnt >= i_wait)
    begin
      o_ack <= 1'b1;
      cnt   <= 4'h0;
      if (i_we)
        words[i_addr[9:2]] <= i_wdata;
      else
        o_rdata <= words[i_addr[9:2]];
    end
    else
    begin
      o_ack   <= 1'b0;
      cnt     <= i_req ? cnt + 4'h1 : 4'h0;
      // data is only good beside ack, so scramble it elsewhere
      o_rdata <= ~o_rdata;
    end
endmodule
`default_nettype wire

// File: tb_sg_descriptor_fetch.sv
// self-checking bench for the descriptor fetch engine
`timescale 1ns/1ps
`default_nettype none
module tb_sg_descriptor_fetch;
  typedef struct packed {logic ch; logic [2:0] md; logic [31:0] blo; logic [31:0] cw;
                  logic [22:0] cnt; logic [3:0] wt;} sgd_row_t;
  logic i_ref_clk = 0, i_rst = 1, i_wr = 0, i_rd = 0, i_buf_done = 0, i_app_wr = 0;
  logic [7:0]  i_addr = 0;
  logic [31:0] i_wdata = 0, i_app_data = 0, s, o_rdata, o_mem_wdata, mem_rdata;
  logic [2:0]  i_app_idx = 0;
  logic [22:0] i_buf_count = 0, o_buf_len;
  logic [3:0]  mem_wait = 0;
  logic [63:0] o_mem_addr, o_buf_addr;
  logic o_irq, o_mem_req, o_mem_we, mem_ack, o_buf_valid, o_buf_chan, o_buf_first, o_buf_last;
  int bad_count = 0, checks_done = 0, b;
  // mode bits are {interrupt, wide, user}; the upper buffer word is always 0xA0
  // buffer addresses stay word aligned, as a mover without realignment needs
  sgd_row_t rows [5] = '{
    '{1'b0, 3'b100, 32'h1000_0000, 32'h0C00_0001, 23'h00_0001, 4'h0},
    '{1'b1, 3'b101, 32'h2000_0040, 32'h0800_1234, 23'h00_1200, 4'h2},
    '{1'b0, 3'b110, 32'h3000_0000, 32'h047F_FFFF, 23'h7F_FFFF, 4'h1},
    '{1'b1, 3'b111, 32'h4000_0100, 32'h0C00_0100, 23'h00_0080, 4'h3},
    '{1'b0, 3'b001, 32'h5000_0010, 32'h0400_0020, 23'h00_0010, 4'h0}};
  sgd_row_t r;
  always #4 i_ref_clk = ~i_ref_clk;
  sgd_fetch dut (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq), .o_mem_req(o_mem_req),
    .o_mem_we(o_mem_we), .o_mem_addr(o_mem_addr), .o_mem_wdata(o_mem_wdata),
    .i_mem_ack(mem_ack), .i_mem_rdata(mem_rdata), .o_buf_valid(o_buf_valid),
    .o_buf_chan(o_buf_chan), .o_buf_addr(o_buf_addr), .o_buf_len(o_buf_len),
    .o_buf_first(o_buf_first), .o_buf_last(o_buf_last), .i_buf_done(i_buf_done),
    .i_buf_count(i_buf_count), .i_app_wr(i_app_wr), .i_app_idx(i_app_idx),
    .i_app_data(i_app_data));
  sgd_mem_model mem (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_req(o_mem_req),
    .i_we(o_mem_we), .i_addr(o_mem_addr), .i_wdata(o_mem_wdata), .i_wait(mem_wait),
    .o_ack(mem_ack), .o_rdata(mem_rdata));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_ref_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask
  task automatic pulse_done(input logic [22:0] c);
    @(posedge i_ref_clk);
    i_buf_done <= 1'b1;
    i_buf_count <= c;
    @(posedge i_ref_clk);
    i_buf_done <= 1'b0;
  endtask
  // the #1 lets a retiring command drop before it is looked at
  task automatic wait_buf;
    int n;
    n = 0;
    #1;
    while (o_buf_valid !== 1'b1 && n < 400)
    begin
      @(posedge i_ref_clk);
      #1 n++;
    end
    if (n == 400)
    begin
      bad_count++;
      print_verdict;
    end
  endtask
  // an engine that runs past the tail never reaches idle and times out here
  task automatic wait_idle;
    logic [31:0] st;
    int n;
    st = 32'h1;
    n = 0;
    while (st[0] !== 1'b0 && n < 100)
    begin
      rd(8'h04, st);
      n++;
    end
    if (n == 100)
    begin
      bad_count++;
      print_verdict;
    end
  endtask
  // lay one descriptor down at word index i of the memory
  task automatic put_desc(input int i, input logic [31:0] nxt, blo, cw);
    mem.words[i] = nxt;
    mem.words[i + 1] = 32'h0000_0077;
    mem.words[i + 2] = blo;
    mem.words[i + 3] = 32'h0000_00A0;
    mem.words[i + 6] = cw;
    mem.words[i + 7] = 32'h0000_0000;
    mem.words[i + 8] = 32'hC0DE_0000 + i;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (2) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    rd(8'h04, s);
    chk(s, 0);
    rd(8'hF0, s);
    chk({s, o_irq, o_mem_req, o_buf_valid}, 0);
    $display("reset test finished");
    wr(8'h0C, 32'h0000_0003);
    for (int k = 0; k < 5; k++)
    begin
      r = rows[k];
      b = 16 * (k + 1);
      mem_wait <= r.wt;
      put_desc(b, 32'h40 * (k + 1), r.blo, r.cw);
      wr(8'h00, {27'h0, r.md, 2'b00} | (32'h1 << r.ch));
      // current pointer first: a write to either tail half starts the chain
      wr(8'h14 + {r.ch, 4'h0}, 0);
      wr(8'h10 + {r.ch, 4'h0}, 32'h40 * (k + 1));
      wr(8'h1C + {r.ch, 4'h0}, 0);
      wr(8'h18 + {r.ch, 4'h0}, 32'h40 * (k + 1));
      wait_buf;
      chk(o_buf_chan, r.ch);
      chk(o_buf_addr, {r.md[1] ? 32'h0000_00A0 : 32'h0, r.blo});
      chk(o_buf_len, r.cw[22:0]);
      chk({o_buf_first, o_buf_last}, r.cw[27:26]);
      @(posedge i_ref_clk);
      i_app_wr <= r.ch;
      i_app_data <= 32'h5A5A_0000 + k;
      @(posedge i_ref_clk);
      i_app_wr <= 1'b0;
      pulse_done(r.cnt);
      wait_idle;
      chk(mem.words[b + 7], {1'b1, 8'h00, r.cnt});
      chk(mem.words[b + 8], r.ch && r.md[0] ? 32'h5A5A_0000 + k : 32'hC0DE_0000 + b);
      rd(8'h08, s);
      chk(s[1:0], r.md[2] ? 2'b01 << r.ch : 2'b00);
      chk(o_irq, r.md[2]);
      wr(8'h08, 32'h0000_0003);
      repeat (2) @(posedge i_ref_clk);
      chk(o_irq, 0);
      $display("row %0d finished", k);
    end
    // two-descriptor chain, slow memory, interrupt masked until the end
    mem_wait <= 4'h1;
    put_desc(128, 32'h0000_0240, 32'h6000_0000, 32'h0800_0010);
    put_desc(144, 32'h0000_0200, 32'h7000_0000, 32'h0400_0020);
    wr(8'h0C, 0);
    wr(8'h00, 32'h0000_0011);
    wr(8'h10, 32'h0000_0200);
    wr(8'h18, 32'h0000_0240);
    wait_buf;
    chk(o_buf_addr, 64'h0000_0000_6000_0000);
    chk({o_buf_first, o_buf_last}, 2'b10);
    pulse_done(23'h00_0010);
    wait_buf;
    chk(o_buf_addr, 64'h0000_0000_7000_0000);
    chk({o_buf_first, o_buf_last}, 2'b01);
    pulse_done(23'h00_0020);
    wait_idle;
    chk(mem.words[151], 32'h8000_0020);
    rd(8'h08, s);
    chk({s[0], o_irq}, 2'b10);
    wr(8'h0C, 32'h0000_0001);
    repeat (2) @(posedge i_ref_clk);
    chk(o_irq, 1);
    wr(8'h08, 32'h0000_0001);
    repeat (2) @(posedge i_ref_clk);
    chk(o_irq, 0);
    $display("chain test finished");
    // reset while a command stands: everything drops and the chains stay stopped
    wr(8'h18, 32'h0000_0200);
    wait_buf;
    @(posedge i_ref_clk);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    #1 chk({o_irq, o_mem_req, o_buf_valid, o_rdata}, 0);
    rd(8'h04, s);
    chk(s, 0);
    rd(8'h10, s);
    chk(s, 0);
    // a run bit alone must not start a chain without a tail write
    wr(8'h00, 32'h0000_0001);
    repeat (4) @(posedge i_ref_clk);
    chk(o_mem_req, 0);
    $display("mid-run reset test finished");
    print_verdict;
  end
endmodule
`default_nettype wire
